// *** flash_cmd_pkg.sv ***
// Shared constants and types for the flash setting-command decoder.
// Assumes a single system clock; the serial link pins are sampled, not used as clocks.
package flash_cmd_pkg;

  // Opcodes of the register and setting commands
  localparam logic [7:0] SET_WRITE_LATCH_CMD     = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD   = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD         = 8'h05;
  localparam logic [7:0] CONFIG_READ_CMD         = 8'h15;
  localparam logic [7:0] STATUS_CONFIG_WRITE_CMD = 8'h01;
  localparam logic [7:0] PROTECT_SELECT_CMD      = 8'h68;
  localparam logic [7:0] QUAD_MODE_ENTER_CMD     = 8'h35;
  localparam logic [7:0] QUAD_MODE_EXIT_CMD      = 8'hF5;
  localparam logic [7:0] WIDE_ADDR_ENTER_CMD     = 8'hB7;
  localparam logic [7:0] WIDE_ADDR_EXIT_CMD      = 8'hE9;
  localparam logic [7:0] SUSPEND_CMD             = 8'hB0;
  localparam logic [7:0] POWER_WAKE_CMD          = 8'hAB;

  // Field positions
  localparam int BUSY_BIT      = 0;  // Status bit 0: program/erase in progress
  localparam int LATCH_BIT     = 1;  // Status bit 1: write enable latch
  localparam int FOUR_BYTE_BIT = 5;  // Configuration bit 5: 4-byte addressing
  localparam int SERIAL_IN_BIT = 0;  // Single-line input lane
  localparam int SERIAL_OUT_BIT = 1; // Single-line output lane

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // Bit counts per byte and per sampled clock edge
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] QUAD_STEP     = 4'h4;
  localparam logic [3:0] SINGLE_STEP   = 4'h1;

  // Output enable masks
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_QUAD   = 4'hF;

  // One sample of the link, taken in the system clock domain
  typedef struct packed {
    logic       sclk_rise;
    logic       sclk_fall;
    logic       frame_active;
    logic [3:0] io;
  } link_sample_type;

  // Decoder states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_OPCODE = 5'h02,
    ST_WRITE  = 5'h04,
    ST_READ   = 5'h08,
    ST_IGNORE = 5'h10
  } dec_state_type;

endpackage : flash_cmd_pkg

// *** link_sync.sv ***
// Brings the serial link pins into the system clock domain and finds clock edges.
// Assumes the link clock is several times slower than i_clk_sys.
`timescale 1ns/100ps
module link_sync
  import flash_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic            i_clk_sys,
  input  wire logic            i_reset_n,
  // Raw link pins
  input  wire logic            i_sclk,
  input  wire logic            i_cs_n,
  input  wire logic [3:0]      i_io,
  // Synchronised sample
  output link_sample_type      o_sample
);

  logic [5:0]      raw;
  logic [5:0]      meta_r;
  logic [5:0]      sync_r;
  logic            sclk_prev_r;
  link_sample_type sample_nxt;
  link_sample_type sample_r;

  assign raw = {i_sclk, i_cs_n, i_io};

  // Two-stage synchroniser per pin; first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_sync
      always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
          meta_r[g] <= 1'b1;
          sync_r[g] <= 1'b1;
        end else begin
          meta_r[g] <= raw[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  // Edge detection on the synchronised clock
  always_comb begin
    sample_nxt.sclk_rise    = sync_r[5] & ~sclk_prev_r;
    sample_nxt.sclk_fall    = ~sync_r[5] & sclk_prev_r;
    sample_nxt.frame_active = ~sync_r[4];
    sample_nxt.io           = sync_r[3:0];
  end

  // Registered so edge flags and data stay aligned
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_prev_r <= 1'b1;
      sample_r    <= '0;
    end else begin
      sclk_prev_r <= sync_r[5];
      sample_r    <= sample_nxt;
    end
  end

  assign o_sample = sample_r;

endmodule : link_sync

// *** byte_shifter.sv ***
// Assembles incoming bits into bytes, one lane or four lanes per clock edge.
// Assumes the sample comes from link_sync; the count restarts whenever a frame ends.
`timescale 1ns/100ps
module byte_shifter
  import flash_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic            i_clk_sys,
  input  wire logic            i_reset_n,
  // Link sample and lane mode
  input  wire link_sample_type i_sample,
  input  wire logic            i_quad,
  // Received byte
  output logic [7:0]           o_byte,
  output logic                 o_byte_valid
);

  logic [7:0] shift_r, shift_nxt;
  logic [3:0] count_r, count_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic       valid_r, valid_nxt;
  logic [3:0] step;

  // Shift on each rising link clock; MSB first
  always_comb begin
    step      = i_quad ? QUAD_STEP : SINGLE_STEP;
    shift_nxt = shift_r;
    count_nxt = count_r;
    byte_nxt  = byte_r;
    valid_nxt = 1'b0;
    if (!i_sample.frame_active) begin
      count_nxt = 4'h0;
    end else if (i_sample.sclk_rise) begin
      shift_nxt = i_quad ? {shift_r[3:0], i_sample.io} : {shift_r[6:0], i_sample.io[SERIAL_IN_BIT]};
      if (count_r + step == BITS_PER_BYTE) begin
        count_nxt = 4'h0;
        byte_nxt  = shift_nxt;
        valid_nxt = 1'b1;
      end else begin
        count_nxt = count_r + step;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_r <= 8'h00;
      count_r <= 4'h0;
      byte_r  <= 8'h00;
      valid_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      count_r <= count_nxt;
      byte_r  <= byte_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign o_byte       = byte_r;
  assign o_byte_valid = valid_r;

endmodule : byte_shifter

// *** flash_setting_command_decoder.sv ***
// Decoder for register and setting commands of a serial multi-lane flash.
// Assumes the host drives the link clock and chip select; pins are sampled by i_clk_sys.
`timescale 1ns/100ps
// Notes on behaviour
// - opcode 06h sets the write enable latch in either mode.
// - opcode 04h clears the write enable latch in either mode.
// - opcode 05h shifts out the status register.
// - opcode 15h shifts out the configuration register.
// - opcode 01h then one or two bytes load status, then configuration.
// - opcode 68h enters individual block protection mode.
// - opcode 35h enters quad mode, only accepted from single-line mode.
// - opcode F5h returns to single-line mode, only accepted in quad mode.
// - opcode B7h sets the four-byte address flag.
// - opcode E9h clears the four-byte address flag.
// - opcode B0h suspends an ongoing program or erase.
// - opcode ABh wakes the device from deep power-down.
module flash_setting_command_decoder
  import flash_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  // Serial link pins
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic [3:0] i_io,
  output logic      [3:0] o_io,
  output logic      [3:0] o_io_oe,
  // Device state inputs
  input  wire logic       i_busy,
  // Decoded state and events
  output logic            o_write_enable_latch,
  output logic            o_quad_peripheral_mode,
  output logic            o_four_byte_address_flag,
  output logic            o_block_protect_mode,
  output logic            o_suspend_pulse,
  output logic            o_wake_pulse,
  output logic      [7:0] o_status_reg,
  output logic      [7:0] o_config_reg
);

  link_sample_type sample;
  logic [7:0]      rx_byte;
  logic            rx_valid;
  dec_state_type   state_r, state_nxt;
  logic            wel_r, wel_nxt;
  logic            quad_r, quad_nxt;
  logic            four_byte_r, four_byte_nxt;
  logic            protect_r, protect_nxt;
  logic            suspend_r, suspend_nxt;
  logic            wake_r, wake_nxt;
  logic [7:0]      status_r, status_nxt;
  logic [7:0]      config_r, config_nxt;
  logic            wr_idx_r, wr_idx_nxt;
  logic [7:0]      tx_r, tx_nxt;
  logic [3:0]      io_r, io_nxt;
  logic [3:0]      oe_r, oe_nxt;
  logic [7:0]      status_view;
  logic [7:0]      config_view;
  logic            opcode_strobe;

  // Pin synchroniser and byte assembly
  link_sync u_link_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_sclk    (i_sclk),
    .i_cs_n    (i_cs_n),
    .i_io      (i_io),
    .o_sample  (sample)
  );

  byte_shifter u_byte_shifter (
    .i_clk_sys    (i_clk_sys),
    .i_reset_n    (i_reset_n),
    .i_sample     (sample),
    .i_quad       (quad_r),
    .o_byte       (rx_byte),
    .o_byte_valid (rx_valid)
  );

  // Live bits merged into the readable register images
  always_comb begin
    status_view                = status_r;
    status_view[BUSY_BIT]      = i_busy;
    status_view[LATCH_BIT]     = wel_r;
    config_view                = config_r;
    config_view[FOUR_BYTE_BIT] = four_byte_r;
  end

  // A byte completing as chip select rises is dropped, so the strobe needs an open frame
  assign opcode_strobe = rx_valid && (state_r == ST_OPCODE) && sample.frame_active;

  // Command decode, register updates and read-out shifting
  always_comb begin
    state_nxt     = state_r;
    wel_nxt       = wel_r;
    quad_nxt      = quad_r;
    four_byte_nxt = four_byte_r;
    protect_nxt   = protect_r;
    suspend_nxt   = 1'b0;
    wake_nxt      = 1'b0;
    status_nxt    = status_r;
    config_nxt    = config_r;
    wr_idx_nxt    = wr_idx_r;
    tx_nxt        = tx_r;
    io_nxt        = io_r;
    oe_nxt        = oe_r;
    if (!sample.frame_active) begin
      // Chip select high ends every frame and releases the lanes
      state_nxt  = ST_IDLE;
      wr_idx_nxt = 1'b0;
      oe_nxt     = 4'h0;
      io_nxt     = 4'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_OPCODE;
        end
        ST_OPCODE: begin
          if (rx_valid) begin
            state_nxt = ST_IGNORE;
            case (rx_byte)
              SET_WRITE_LATCH_CMD: wel_nxt = 1'b1;
              CLEAR_WRITE_LATCH_CMD: wel_nxt = 1'b0;
              STATUS_READ_CMD: begin
                state_nxt = ST_READ;
                tx_nxt    = status_view;
                oe_nxt    = quad_r ? OE_QUAD : OE_SINGLE;
              end
              CONFIG_READ_CMD: begin
                state_nxt = ST_READ;
                tx_nxt    = config_view;
                oe_nxt    = quad_r ? OE_QUAD : OE_SINGLE;
              end
              STATUS_CONFIG_WRITE_CMD: state_nxt = ST_WRITE;
              PROTECT_SELECT_CMD: protect_nxt = 1'b1;
              QUAD_MODE_ENTER_CMD: quad_nxt = 1'b1;
              QUAD_MODE_EXIT_CMD: quad_nxt = 1'b0;
              WIDE_ADDR_ENTER_CMD: four_byte_nxt = 1'b1;
              WIDE_ADDR_EXIT_CMD: four_byte_nxt = 1'b0;
              SUSPEND_CMD: suspend_nxt = 1'b1;
              POWER_WAKE_CMD: wake_nxt = 1'b1;
              default: state_nxt = ST_IGNORE;
            endcase
          end
        end
        ST_WRITE: begin
          if (rx_valid) begin
            if (!wr_idx_r) begin
              status_nxt           = rx_byte;
              status_nxt[BUSY_BIT] = status_r[BUSY_BIT];
              status_nxt[LATCH_BIT] = status_r[LATCH_BIT];
              wr_idx_nxt           = 1'b1;
            end else begin
              config_nxt                = rx_byte;
              config_nxt[FOUR_BYTE_BIT] = config_r[FOUR_BYTE_BIT];
              state_nxt                 = ST_IGNORE;
            end
          end
        end
        ST_READ: begin
          // Falling edges drive out MSB first; register repeats until chip select rises
          if (sample.sclk_fall) begin
            if (quad_r) begin
              io_nxt = tx_r[7:4];
              tx_nxt = {tx_r[3:0], tx_r[7:4]};
            end else begin
              io_nxt                 = 4'h0;
              io_nxt[SERIAL_OUT_BIT] = tx_r[7];
              tx_nxt                 = {tx_r[6:0], tx_r[7]};
            end
          end
        end
        ST_IGNORE: state_nxt = ST_IGNORE;
        default: state_nxt = ST_IDLE;
      endcase
    end
    // entry refused while already in quad
    if (opcode_strobe && rx_byte == QUAD_MODE_ENTER_CMD && quad_r) begin
      quad_nxt = quad_r;
    end
    if (opcode_strobe && rx_byte == QUAD_MODE_EXIT_CMD && !quad_r) begin
      quad_nxt = quad_r;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r     <= ST_IDLE;
      wel_r       <= 1'b0;
      quad_r      <= 1'b0;
      four_byte_r <= 1'b0;
      protect_r   <= 1'b0;
      suspend_r   <= 1'b0;
      wake_r      <= 1'b0;
      status_r    <= STATUS_RESET;
      config_r    <= CONFIG_RESET;
      wr_idx_r    <= 1'b0;
      tx_r        <= 8'h00;
      io_r        <= 4'h0;
      oe_r        <= 4'h0;
    end else begin
      state_r     <= state_nxt;
      wel_r       <= wel_nxt;
      quad_r      <= quad_nxt;
      four_byte_r <= four_byte_nxt;
      protect_r   <= protect_nxt;
      suspend_r   <= suspend_nxt;
      wake_r      <= wake_nxt;
      status_r    <= status_nxt;
      config_r    <= config_nxt;
      wr_idx_r    <= wr_idx_nxt;
      tx_r        <= tx_nxt;
      io_r        <= io_nxt;
      oe_r        <= oe_nxt;
    end
  end

  // Outputs straight from flip-flops, except o_status_reg bit 0, which comes straight from i_busy
  assign o_io                     = io_r;
  assign o_io_oe                  = oe_r;
  assign o_write_enable_latch     = wel_r;
  assign o_quad_peripheral_mode   = quad_r;
  assign o_four_byte_address_flag = four_byte_r;
  assign o_block_protect_mode     = protect_r;
  assign o_suspend_pulse          = suspend_r;
  assign o_wake_pulse             = wake_r;
  assign o_status_reg             = status_view;
  assign o_config_reg             = config_view;

  // Checks on decode results
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  sequence opcode_seen(logic [7:0] code);
    opcode_strobe && (rx_byte == code);
  endsequence

  sequence one_pulse(logic sig);
    sig ##1 !sig;
  endsequence

  a_latch_set: assert property (opcode_seen(SET_WRITE_LATCH_CMD) |=> wel_r)
    else $error("write latch not set");
  a_latch_clear: assert property (opcode_seen(CLEAR_WRITE_LATCH_CMD) |=> !wel_r)
    else $error("write latch not cleared");
  a_status_read: assert property (opcode_seen(STATUS_READ_CMD)
    |=> state_r == ST_READ && tx_r == $past(status_view) && oe_r != 4'h0)
    else $error("status read-out not loaded");
  a_config_read: assert property (opcode_seen(CONFIG_READ_CMD)
    |=> state_r == ST_READ && tx_r == $past(config_view))
    else $error("config read-out not loaded");
  a_status_load: assert property (state_r == ST_WRITE && rx_valid && !wr_idx_r && sample.frame_active
    |=> status_r[7:2] == $past(rx_byte[7:2]) && wr_idx_r)
    else $error("status byte not loaded");
  a_protect_entry: assert property (opcode_seen(PROTECT_SELECT_CMD) |=> protect_r)
    else $error("block protect mode not entered");
  a_quad_enter: assert property (opcode_seen(QUAD_MODE_ENTER_CMD) |=> quad_r)
    else $error("quad mode not entered");
  a_quad_exit: assert property (opcode_seen(QUAD_MODE_EXIT_CMD) |=> !quad_r)
    else $error("quad mode not left");
  a_wide_enter: assert property (opcode_seen(WIDE_ADDR_ENTER_CMD) |=> four_byte_r && config_view[FOUR_BYTE_BIT])
    else $error("four-byte flag not set");
  a_wide_exit: assert property (opcode_seen(WIDE_ADDR_EXIT_CMD) |=> !four_byte_r)
    else $error("four-byte flag not cleared");
  a_suspend_pulse: assert property (opcode_seen(SUSPEND_CMD) |=> one_pulse(suspend_r))
    else $error("suspend pulse wrong");
  a_wake_pulse: assert property (opcode_seen(POWER_WAKE_CMD) |=> one_pulse(wake_r))
    else $error("wake pulse wrong");
  a_unknown_ignored: assert property (opcode_strobe && rx_byte == 8'h41
    |=> state_r != ST_READ && $stable(wel_r) && $stable(quad_r) && $stable(four_byte_r))
    else $error("unknown opcode had an effect");

endmodule : flash_setting_command_decoder

// *** flash_host_model.sv ***
// Host controller model that drives command frames onto the serial link.
// Assumes the bench resolves the shared data lanes and feeds the result back on i_io.
`timescale 1ns/100ps
module flash_host_model (
  // Pacing clock
  input  wire logic       i_clk_sys,
  // Link pins towards the device
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic      [3:0] o_io,
  // Resolved lane levels
  input  wire logic [3:0] i_io
);
  // Link clock parks high between frames
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : hold

  // One frame: opcode and data out, then nrd bytes sampled back
  task automatic frame(input logic [7:0] tx[$], input bit quad, input int nrd, output logic [7:0] rx[$]);
    logic [7:0] b;
    int         steps;
    rx = {};
    steps = quad ? 2 : 8;
    @(posedge i_clk_sys);
    o_cs_n <= 1'b0;
    hold(4);
    foreach (tx[k]) begin
      for (int s = 0; s < steps; s++) begin
        o_sclk <= 1'b0;
        o_io <= quad ? (s == 0 ? tx[k][7:4] : tx[k][3:0]) : {~o_io[3:1], tx[k][7 - s]};
        hold(4);
        o_sclk <= 1'b1;
        hold(4);
      end
    end
    // Lanes released: toggle so a stale level never passes for data
    for (int r = 0; r < nrd; r++) begin
      b = 8'h00;
      for (int s = 0; s < steps; s++) begin
        o_sclk <= 1'b0;
        o_io <= ~o_io;
        hold(4);
        o_sclk <= 1'b1;
        hold(4);
        b = quad ? {b[3:0], i_io} : {b[6:0], i_io[1]};
      end
      rx.push_back(b);
    end
    o_cs_n <= 1'b1;
    o_io <= ~o_io;
    hold(6);
  endtask : frame
endmodule : flash_host_model

// *** tb_top.sv ***
// Self-checking bench for the flash setting-command decoder.
// Assumes the host model paces frames; expectations kept in local shadow variables.
`timescale 1ns/100ps
module tb_top;
  import flash_cmd_pkg::*;
  logic       clk_sys, reset_n, busy, sclk, cs_n;
  logic [3:0] host_io, line_io, dev_io, dev_oe;
  logic       write_enable_latch, quad_mode, four_flag, protect, suspend_p, wake_p;
  logic [7:0] status_reg, config_reg, exp_stat, exp_cfg;
  logic       exp_wel, exp_four, exp_protect;
  logic [7:0] rx[$];
  int         error_cnt, check_count, cycles, suspend_cnt, wake_cnt;
  bit         quad;

  flash_setting_command_decoder uut (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_io(line_io), .o_io(dev_io), .o_io_oe(dev_oe), .i_busy(busy),
    .o_write_enable_latch(write_enable_latch), .o_quad_peripheral_mode(quad_mode),
    .o_four_byte_address_flag(four_flag), .o_block_protect_mode(protect),
    .o_suspend_pulse(suspend_p), .o_wake_pulse(wake_p),
    .o_status_reg(status_reg), .o_config_reg(config_reg));

  flash_host_model host (.i_clk_sys(clk_sys), .o_sclk(sclk), .o_cs_n(cs_n), .o_io(host_io), .i_io(line_io));

  // Device lanes win where enabled, host lanes elsewhere
  assign line_io = (dev_oe & dev_io) | (~dev_oe & host_io);

  always #20 clk_sys = ~clk_sys;

  // Pulse counting and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (suspend_p === 1'b1) suspend_cnt++;
    if (wake_p === 1'b1) wake_cnt++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  function automatic logic [7:0] exp_status();
    return {exp_stat[7:2], exp_wel, busy};
  endfunction : exp_status

  function automatic logic [7:0] exp_config();
    return {exp_cfg[7:6], exp_four, exp_cfg[4:0]};
  endfunction : exp_config

  task automatic cmd(input logic [7:0] tx[$], input int nrd);
    host.frame(tx, quad, nrd, rx);
  endtask : cmd

  // Sampled mid-cycle so no output is read in the step that launches it
  task automatic chk_state(input string what);
    @(negedge clk_sys);
    chk({7'h00, write_enable_latch}, {7'h00, exp_wel}, what);
    chk({7'h00, quad_mode}, {7'h00, quad}, what);
    chk({7'h00, four_flag}, {7'h00, exp_four}, what);
    chk({7'h00, protect}, {7'h00, exp_protect}, what);
    chk(status_reg, exp_status(), what);
    chk(config_reg, exp_config(), what);
    chk({4'h0, dev_oe}, 8'h00, what);
    @(posedge clk_sys);
  endtask : chk_state

  // Async reset held 20 cycles, then idle before the first frame
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    {exp_wel, exp_four, exp_protect, exp_stat, exp_cfg} = '0;
    chk_state("reset");
  endtask : do_reset

  // Every command except quad enter and exit, in the current lane mode
  task automatic t_pass(input logic [7:0] s_val, input logic [7:0] c_val);
    cmd({SET_WRITE_LATCH_CMD}, 0);
    exp_wel = 1'b1;
    chk_state("latch set");
    cmd({CLEAR_WRITE_LATCH_CMD, SET_WRITE_LATCH_CMD}, 0);
    exp_wel = 1'b0;
    chk_state("latch clear");
    cmd({STATUS_CONFIG_WRITE_CMD, s_val, c_val, ~s_val}, 0);
    exp_stat = s_val;
    exp_cfg = c_val;
    chk_state("write two");
    cmd({STATUS_CONFIG_WRITE_CMD, ~s_val}, 0);
    exp_stat = ~s_val;
    chk_state("write one");
    busy <= 1'b1;
    cmd({STATUS_READ_CMD}, 2);
    chk(rx[0], exp_status(), "status read");
    chk(rx[1], exp_status(), "status repeat");
    busy <= 1'b0;
    cmd({CONFIG_READ_CMD}, 1);
    chk(rx[0], exp_config(), "config read");
    cmd({PROTECT_SELECT_CMD}, 0);
    exp_protect = 1'b1;
    cmd({WIDE_ADDR_ENTER_CMD}, 0);
    exp_four = 1'b1;
    chk_state("protect four");
    cmd({8'h41, WIDE_ADDR_EXIT_CMD}, 0);
    chk_state("unknown");
    cmd({WIDE_ADDR_EXIT_CMD}, 0);
    exp_four = 1'b0;
    chk_state("four clear");
    suspend_cnt = 0;
    wake_cnt = 0;
    cmd({SUSPEND_CMD}, 0);
    cmd({POWER_WAKE_CMD}, 0);
    chk(suspend_cnt[7:0], 8'h01, "suspend");
    chk(wake_cnt[7:0], 8'h01, "wake");
  endtask : t_pass

  // Main sequence: single pass, quad pass, exit, reset again
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    busy = 1'b0;
    quad = 1'b0;
    error_cnt = 0;
    check_count = 0;
    cycles = 0;
    do_reset();
    cmd({QUAD_MODE_EXIT_CMD}, 0);
    chk_state("exit refused");
    t_pass(8'hFE, 8'hA5);
    cmd({QUAD_MODE_ENTER_CMD}, 0);
    quad = 1'b1;
    chk_state("quad enter");
    cmd({QUAD_MODE_ENTER_CMD}, 0);
    chk_state("enter refused");
    t_pass(8'h81, 8'h5A);
    cmd({QUAD_MODE_EXIT_CMD}, 0);
    quad = 1'b0;
    chk_state("quad exit");
    do_reset();
    stop_test();
  end
endmodule : tb_top
